/* pdspt_pkg.sv */
// Purpose: Shared constants and carriers for the source policy timer block
// Assumes: 25 MHz system clock, inputs already synchronous
// Notes: Times kept in their own units, cycle counts derived from them
package pdspt_pkg;

    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned CYC_PER_US = CLK_HZ / 1000000;

    localparam int unsigned T_PROT_ARM_MS = 190;
    localparam int unsigned T_SETTLE_MS = 260;
    localparam int unsigned T_SRC_RECOVER_MS = 765;
    localparam int unsigned T_HR_GATE_OFF_MS = 30;
    localparam int unsigned T_ATTACH_DEB_MS = 185;
    localparam int unsigned T_SNK_TRANS_MS = 24;
    localparam int unsigned T_FAULT_RETRY_MS = 1395;
    localparam int unsigned T_SHORT_RETRY_MS = 985;
    localparam int unsigned T_TURN_ON_MS = 600;
    localparam int unsigned T_SILENCE_RETRY_MS = 4800;
    localparam int unsigned T_AUX_RAIL_MAX_MS = 5;
    localparam int unsigned T_FAST_OFF_MAX_US = 30;
    localparam int unsigned T_DSCG_STOP_MAX_US = 10;

    // Least times round up; all are whole milliseconds so exact
    localparam int unsigned C_PROT_ARM = T_PROT_ARM_MS * CYC_PER_MS;
    localparam int unsigned C_SETTLE = T_SETTLE_MS * CYC_PER_MS;
    localparam int unsigned C_SRC_RECOVER = T_SRC_RECOVER_MS * CYC_PER_MS;
    localparam int unsigned C_HR_GATE_OFF = T_HR_GATE_OFF_MS * CYC_PER_MS;
    localparam int unsigned C_ATTACH_DEB = T_ATTACH_DEB_MS * CYC_PER_MS;
    localparam int unsigned C_SNK_TRANS = T_SNK_TRANS_MS * CYC_PER_MS;
    localparam int unsigned C_FAULT_RETRY = T_FAULT_RETRY_MS * CYC_PER_MS;
    localparam int unsigned C_SHORT_RETRY = T_SHORT_RETRY_MS * CYC_PER_MS;
    localparam int unsigned C_TURN_ON = T_TURN_ON_MS * CYC_PER_MS;
    localparam int unsigned C_SILENCE_RETRY = T_SILENCE_RETRY_MS * CYC_PER_MS;
    // Longest times round down; the design meets them in one cycle
    localparam int unsigned C_AUX_RAIL_MAX = T_AUX_RAIL_MAX_MS * CYC_PER_MS;
    localparam int unsigned C_FAST_OFF_MAX = T_FAST_OFF_MAX_US * CYC_PER_US;
    localparam int unsigned C_DSCG_STOP_MAX = T_DSCG_STOP_MAX_US * CYC_PER_US;

    localparam int CNT_W = 32;
    localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;
    localparam logic [1:0] SEL_DEFAULT = 2'h0;

    typedef enum logic [2:0] {
        PDSPT_IDLE = 3'b000,
        PDSPT_DEBOUNCE = 3'b001,
        PDSPT_POWERED = 3'b010,
        PDSPT_HR_TX = 3'b011,
        PDSPT_HR_HOLD = 3'b100,
        PDSPT_RECOVER = 3'b101
    } pdspt_state_t;

    typedef enum logic [1:0] {
        PDSPT_TR_IDLE = 2'b00,
        PDSPT_TR_WAIT = 2'b01,
        PDSPT_TR_SETTLE = 2'b10
    } pdspt_trans_t;

    // Sensed conditions and link events
    typedef struct packed {
        logic sink_present;
        logic gate_disable_input_n;
        logic main_supply_input;
        logic vbus_short;
        logic fast_ovp;
        logic ocp_large;
        logic high_current_mode;
        logic first_thermal_trip;
        logic pd_msg_rx;
        logic request_accepted;
        logic [1:0] request_sel;
        logic hard_reset_done;
    } pdspt_sense_t;

    // Driven pins and link requests
    typedef struct packed {
        logic attach_indicator_n;
        logic aux_logic_rail_out;
        logic nfet_gate_drive;
        logic protection_armed;
        logic supply_select_0;
        logic supply_select_1;
        logic rp_3a_advertise;
        logic active_discharge_en;
        logic bleed_discharge_en;
        logic hard_reset_tx;
        logic ps_rdy_tx;
    } pdspt_drive_t;

endpackage : pdspt_pkg

/* pdspt_policy_timers.sv */
// Purpose: Attach, power-up, transition and retry sequencing for a PD source
// Assumes: Single 25 MHz clock; sense inputs synchronous and deglitched
// Notes: Long counts are parameters so simulation can shorten them
`timescale 1ns/1ns
module pdspt_policy_timers
    import pdspt_pkg::*;
#(
    parameter int unsigned PROT_ARM_CYC = pdspt_pkg::C_PROT_ARM,
    parameter int unsigned SETTLE_CYC = pdspt_pkg::C_SETTLE,
    parameter int unsigned SRC_RECOVER_CYC = pdspt_pkg::C_SRC_RECOVER,
    parameter int unsigned HR_GATE_OFF_CYC = pdspt_pkg::C_HR_GATE_OFF,
    parameter int unsigned ATTACH_DEB_CYC = pdspt_pkg::C_ATTACH_DEB,
    parameter int unsigned SNK_TRANS_CYC = pdspt_pkg::C_SNK_TRANS,
    parameter int unsigned FAULT_RETRY_CYC = pdspt_pkg::C_FAULT_RETRY,
    parameter int unsigned SHORT_RETRY_CYC = pdspt_pkg::C_SHORT_RETRY,
    parameter int unsigned TURN_ON_CYC = pdspt_pkg::C_TURN_ON,
    parameter int unsigned SILENCE_RETRY_CYC = pdspt_pkg::C_SILENCE_RETRY
)(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire pdspt_pkg::pdspt_sense_t sense,
    output pdspt_pkg::pdspt_drive_t drive
);
    import pdspt_pkg::*;

    localparam logic [CNT_W-1:0] PROT_ARM_L = CNT_W'(PROT_ARM_CYC);
    localparam logic [CNT_W-1:0] SETTLE_L = CNT_W'(SETTLE_CYC);
    localparam logic [CNT_W-1:0] RECOVER_L = CNT_W'(SRC_RECOVER_CYC);
    localparam logic [CNT_W-1:0] HR_OFF_L = CNT_W'(HR_GATE_OFF_CYC);
    localparam logic [CNT_W-1:0] DEB_L = CNT_W'(ATTACH_DEB_CYC);
    localparam logic [CNT_W-1:0] TRANS_L = CNT_W'(SNK_TRANS_CYC);
    localparam logic [CNT_W-1:0] FAULT_L = CNT_W'(FAULT_RETRY_CYC);
    localparam logic [CNT_W-1:0] SHORT_L = CNT_W'(SHORT_RETRY_CYC);
    localparam logic [CNT_W-1:0] TURN_ON_L = CNT_W'(TURN_ON_CYC);
    localparam logic [CNT_W-1:0] SILENCE_L = CNT_W'(SILENCE_RETRY_CYC);

    pdspt_state_t state_q;
    pdspt_trans_t tr_q;
    logic [CNT_W-1:0] seq_cnt_q;
    logic [CNT_W-1:0] prot_cnt_q;
    logic [CNT_W-1:0] retry_cnt_q;
    logic [CNT_W-1:0] tr_cnt_q;
    logic [CNT_W-1:0] retry_lim;
    logic [1:0] sel_q;
    logic [1:0] req_sel_q;
    logic first_retry_q;
    logic thermal_hr_q;
    logic gate_on;
    logic supply_fault;
    logic fast_trip;
    logic retry_due;
    logic start_hr;
    logic detach;
    logic gate_en;

    assign detach = !sense.sink_present && (state_q != PDSPT_IDLE);
    assign gate_on = (state_q == PDSPT_POWERED) || (state_q == PDSPT_HR_TX)
        || ((state_q == PDSPT_HR_HOLD) && (seq_cnt_q < HR_OFF_L));
    assign supply_fault = !sense.gate_disable_input_n || !sense.main_supply_input;
    // large ocp path, only in high-current mode
    assign fast_trip = sense.fast_ovp || (sense.ocp_large && sense.high_current_mode);
    assign gate_en = gate_on && !fast_trip && !detach && sense.gate_disable_input_n;

    always_comb
    begin
        if (supply_fault)
            retry_lim = first_retry_q ? TURN_ON_L : FAULT_L;
        else if (sense.vbus_short)
            retry_lim = SHORT_L;
        else
            retry_lim = SILENCE_L;
    end

    assign retry_due = (retry_cnt_q >= retry_lim);
    assign start_hr = (state_q == PDSPT_POWERED)
        && (retry_due || fast_trip || sense.first_thermal_trip);

    // Main sequence; one counter reused for debounce, hold and recovery
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= PDSPT_IDLE;
            seq_cnt_q <= CNT_ZERO;
            thermal_hr_q <= 1'b0;
        end
        else if (detach)
        begin
            state_q <= PDSPT_IDLE;
            seq_cnt_q <= CNT_ZERO;
            thermal_hr_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                PDSPT_IDLE:
                begin
                    seq_cnt_q <= CNT_ZERO;
                    if (sense.sink_present)
                        state_q <= PDSPT_DEBOUNCE;
                end
                PDSPT_DEBOUNCE:
                begin
                    seq_cnt_q <= seq_cnt_q + CNT_ONE;
                    if (seq_cnt_q >= DEB_L - CNT_ONE)
                        state_q <= PDSPT_POWERED;
                end
                PDSPT_POWERED:
                begin
                    seq_cnt_q <= CNT_ZERO;
                    if (start_hr)
                    begin
                        state_q <= PDSPT_HR_TX;
                        thermal_hr_q <= sense.first_thermal_trip;
                    end
                end
                PDSPT_HR_TX:
                begin
                    if (sense.hard_reset_done)
                        state_q <= PDSPT_HR_HOLD;
                end
                PDSPT_HR_HOLD:
                begin
                    seq_cnt_q <= seq_cnt_q + CNT_ONE;
                    if (seq_cnt_q >= HR_OFF_L)
                    begin
                        seq_cnt_q <= CNT_ZERO;
                        state_q <= thermal_hr_q ? PDSPT_RECOVER : PDSPT_POWERED;
                    end
                end
                PDSPT_RECOVER:
                begin
                    // gate held off, longer while trip persists
                    seq_cnt_q <= seq_cnt_q + CNT_ONE;
                    if (sense.first_thermal_trip)
                        seq_cnt_q <= CNT_ZERO;
                    else if (seq_cnt_q >= RECOVER_L - CNT_ONE)
                        state_q <= PDSPT_POWERED;
                end
                default:
                begin
                    state_q <= PDSPT_IDLE;
                end
            endcase
        end
    end

    // Retry interval counter, restarted on each hard reset and message
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            retry_cnt_q <= CNT_ZERO;
            first_retry_q <= 1'b1;
        end
        else if (state_q == PDSPT_IDLE || state_q == PDSPT_DEBOUNCE || detach)
        begin
            // counters cleared until attach is debounced
            retry_cnt_q <= CNT_ZERO;
            first_retry_q <= 1'b1;
        end
        else if (start_hr)
        begin
            retry_cnt_q <= CNT_ZERO;
            first_retry_q <= 1'b0;
        end
        else if (sense.pd_msg_rx)
            retry_cnt_q <= CNT_ZERO;
        else
            retry_cnt_q <= retry_cnt_q + CNT_ONE;
    end

    // Protection arming; restarts each time gate_on turns back on, not after a fast-trip or disable-input gate cut
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            prot_cnt_q <= CNT_ZERO;
        else if (!gate_on || detach)
            prot_cnt_q <= CNT_ZERO;
        else if (prot_cnt_q < PROT_ARM_L)
            prot_cnt_q <= prot_cnt_q + CNT_ONE;
    end

    // Voltage transition: wait, switch selects, settle, then PS_RDY
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tr_q <= PDSPT_TR_IDLE;
            tr_cnt_q <= CNT_ZERO;
            sel_q <= SEL_DEFAULT;
            req_sel_q <= SEL_DEFAULT;
        end
        else if (state_q != PDSPT_POWERED || detach)
        begin
            // Hard reset or detach returns the supply to default
            tr_q <= PDSPT_TR_IDLE;
            tr_cnt_q <= CNT_ZERO;
            sel_q <= SEL_DEFAULT;
        end
        else
        begin
            case (tr_q)
                PDSPT_TR_IDLE:
                begin
                    tr_cnt_q <= CNT_ZERO;
                    if (sense.request_accepted)
                    begin
                        req_sel_q <= sense.request_sel;
                        tr_q <= PDSPT_TR_WAIT;
                    end
                end
                PDSPT_TR_WAIT:
                begin
                    tr_cnt_q <= tr_cnt_q + CNT_ONE;
                    if (tr_cnt_q >= TRANS_L - CNT_ONE)
                    begin
                        sel_q <= req_sel_q;
                        tr_cnt_q <= CNT_ZERO;
                        tr_q <= PDSPT_TR_SETTLE;
                    end
                end
                PDSPT_TR_SETTLE:
                begin
                    // supply settling, counted from the select pins changing
                    tr_cnt_q <= tr_cnt_q + CNT_ONE;
                    if (tr_cnt_q >= SETTLE_L)
                        tr_q <= PDSPT_TR_IDLE;
                end
                default:
                begin
                    tr_q <= PDSPT_TR_IDLE;
                end
            endcase
        end
    end

    // Registered pin drive
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            drive <= '0;
            drive.attach_indicator_n <= 1'b1;
        end
        else
        begin
            drive.attach_indicator_n <= !(sense.sink_present
                && (state_q != PDSPT_IDLE) && (state_q != PDSPT_DEBOUNCE));
            // aux rail on first cycle of attach
            drive.aux_logic_rail_out <= sense.sink_present;
            // gate cut on fast trip, one cycle
            drive.nfet_gate_drive <= gate_en;
            drive.protection_armed <= gate_on && (prot_cnt_q >= PROT_ARM_L);
            drive.supply_select_0 <= sel_q[0];
            drive.supply_select_1 <= sel_q[1];
            // 3 A from gate turn-on until first message
            if (!gate_en)
                drive.rp_3a_advertise <= 1'b0;
            else if (sense.pd_msg_rx)
                drive.rp_3a_advertise <= 1'b0;
            else if (!drive.nfet_gate_drive)
                drive.rp_3a_advertise <= 1'b1;
            // active discharge stops on thermal trip
            drive.active_discharge_en <= !gate_on && !sense.first_thermal_trip
                && (state_q != PDSPT_IDLE) && (state_q != PDSPT_DEBOUNCE);
            // bleed keeps running through thermal trip
            drive.bleed_discharge_en <= 1'b1;
            drive.hard_reset_tx <= start_hr;
            drive.ps_rdy_tx <= (tr_q == PDSPT_TR_SETTLE)
                && (tr_cnt_q >= SETTLE_L) && !detach
                && (state_q == PDSPT_POWERED);
        end
    end

endmodule : pdspt_policy_timers

/* pdspt_checker.sv */
// Purpose: Port timing checks for the source policy timers
// Assumes: One clock, asynchronous active-low reset
// Notes: Hold window figures suit a gate-off hold of ten cycles
`timescale 1ns/1ns
module pdspt_checker
    import pdspt_pkg::*;
#(
    parameter int unsigned PROT_ARM_CYC = 40,
    parameter int unsigned SETTLE_CYC = 30,
    parameter int unsigned ATTACH_DEB_CYC = 20,
    parameter int unsigned HR_GATE_OFF_CYC = 10
)(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire pdspt_pkg::pdspt_sense_t sense,
    input wire pdspt_pkg::pdspt_drive_t drive
);
    import pdspt_pkg::*;
    localparam int HOLD_LO = HR_GATE_OFF_CYC - 9;
    localparam int HOLD_HI = HR_GATE_OFF_CYC - 6;
    int unsigned sink_cnt_q;
    int unsigned gate_cnt_q;
    int unsigned sel_cnt_q;
    logic [1:0] sel_q;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Lower bounds only: the exact edge is checked by the bench
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sink_cnt_q <= 0;
            gate_cnt_q <= 0;
            sel_cnt_q <= 0;
            sel_q <= 2'h0;
        end
        else
        begin
            sink_cnt_q <= sense.sink_present ? sink_cnt_q + 1 : 0;
            gate_cnt_q <= drive.nfet_gate_drive ? gate_cnt_q + 1 : 0;
            sel_q <= {drive.supply_select_1, drive.supply_select_0};
            sel_cnt_q <= (sel_q != {drive.supply_select_1, drive.supply_select_0})
                ? 0 : sel_cnt_q + 1;
        end
    end
    sequence gate_hold_s;
        drive.nfet_gate_drive [*8];
    endsequence
    sequence gate_drop_s;
        ##[HOLD_LO:HOLD_HI] !drive.nfet_gate_drive;
    endsequence
    property hr_hold_p;
        sense.hard_reset_done && drive.nfet_gate_drive && sense.gate_disable_input_n
            && sense.sink_present && !sense.first_thermal_trip |=> gate_hold_s ##0 gate_drop_s;
    endproperty
    hr_hold_a: assert property (hr_hold_p)
        else $error("gate hold after hard reset wrong");
    aux_rail_a: assert property (sense.sink_present [*3] |-> drive.aux_logic_rail_out)
        else $error("aux rail not raised after attach");
    deb_time_a: assert property ($fell(drive.attach_indicator_n)
        |-> sink_cnt_q >= ATTACH_DEB_CYC + 1)
        else $error("attach indicator before debounce");
    prot_delay_a: assert property ($rose(drive.protection_armed)
        |-> gate_cnt_q >= PROT_ARM_CYC - 1)
        else $error("protection armed too early");
    settle_a: assert property (drive.ps_rdy_tx |-> sel_cnt_q >= SETTLE_CYC - 1)
        else $error("ready sent before settling");
    ovp_off_a: assert property (sense.fast_ovp |-> ##[1:2] !drive.nfet_gate_drive)
        else $error("gate on after fast overvoltage");
    ocp_off_a: assert property (sense.ocp_large && sense.high_current_mode
        |-> ##[1:2] !drive.nfet_gate_drive)
        else $error("gate on after large overcurrent");
    dscg_stop_a: assert property (sense.first_thermal_trip
        |-> ##[1:2] !drive.active_discharge_en)
        else $error("discharge kept after thermal trip");
    bleed_on_a: assert property (rst_n && $past(rst_n, 2) |-> drive.bleed_discharge_en)
        else $error("bleed discharge off");
    rp_start_a: assert property ($rose(drive.rp_3a_advertise)
        |-> drive.nfet_gate_drive)
        else $error("3 A advert without gate");
    rp_drop_a: assert property (sense.pd_msg_rx |-> ##[1:2] !drive.rp_3a_advertise)
        else $error("3 A advert after message");
    detach_a: assert property (!sense.sink_present [*3]
        |-> drive.attach_indicator_n && !drive.nfet_gate_drive
        && !drive.supply_select_0 && !drive.supply_select_1)
        else $error("outputs active after detach");
endmodule : pdspt_checker
bind pdspt_policy_timers pdspt_checker #(.PROT_ARM_CYC(PROT_ARM_CYC), .SETTLE_CYC(SETTLE_CYC),
    .ATTACH_DEB_CYC(ATTACH_DEB_CYC), .HR_GATE_OFF_CYC(HR_GATE_OFF_CYC)) pdspt_checker_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .sense(sense), .drive(drive));

/* pdspt_sink_model.sv */
// Purpose: Link side that ends each hard reset transmission
// Assumes: One request at a time
// Notes: Reply delay set by the bench, prompt or slow
`timescale 1ns/1ns
module pdspt_sink_model (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic hard_reset_tx,
    input wire logic [7:0] reply_delay,
    output logic hard_reset_done
);
    logic [7:0] wait_q;
    logic busy_q;
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wait_q <= 8'h00;
            busy_q <= 1'b0;
            hard_reset_done <= 1'b0;
        end
        else
        begin
            hard_reset_done <= 1'b0;
            if (hard_reset_tx)
            begin
                busy_q <= 1'b1;
                wait_q <= reply_delay;
            end
            else if (busy_q && wait_q <= 8'h01)
            begin
                busy_q <= 1'b0;
                hard_reset_done <= 1'b1;
            end
            else if (busy_q)
                wait_q <= wait_q - 8'h01;
        end
    end
endmodule : pdspt_sink_model

/* pdspt_policy_timers_tb.sv */
// Purpose: Self-checking bench for the source policy timers
// Assumes: Shortened counts, limits spaced apart so each retry kind is told apart
// Notes: Retry windows allow for the hold and reply inside an interval
`timescale 1ns/1ns
module pdspt_policy_timers_tb;
    import pdspt_pkg::*;
    localparam int DEB = 20, PROT = 40, SET = 30, REC = 50, HRG = 10;
    localparam int SNK = 15, FLT = 80, SHT = 35, TON = 55, SIL = 110;
    localparam logic [10:0] M_ATT = 11'h400, M_AUX = 11'h200, M_GATE = 11'h100;
    localparam logic [10:0] M_PROT = 11'h080, M_SEL = 11'h060, M_RP = 11'h010;
    localparam logic [10:0] M_HR = 11'h002, M_RDY = 11'h001, M_DSCG = 11'h008;
    logic sys_clk;
    logic rst_n;
    logic hr_done;
    logic [7:0] hr_delay;
    logic [1:0] sel;
    pdspt_sense_t st;
    pdspt_sense_t sense;
    pdspt_drive_t drive;
    int n_errors;
    int tests_run;
    int n;
    int el;
    pdspt_policy_timers #(.PROT_ARM_CYC(PROT), .SETTLE_CYC(SET), .SRC_RECOVER_CYC(REC),
        .HR_GATE_OFF_CYC(HRG), .ATTACH_DEB_CYC(DEB), .SNK_TRANS_CYC(SNK), .FAULT_RETRY_CYC(FLT),
        .SHORT_RETRY_CYC(SHT), .TURN_ON_CYC(TON), .SILENCE_RETRY_CYC(SIL)) pdspt_policy_timers_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .sense(sense), .drive(drive));
    pdspt_sink_model pdspt_sink_model_i (.sys_clk(sys_clk), .rst_n(rst_n),
        .hard_reset_tx(drive.hard_reset_tx), .reply_delay(hr_delay), .hard_reset_done(hr_done));
    always_comb
    begin
        sense = st;
        sense.hard_reset_done = hr_done;
    end
    // Message and accept inputs are one-cycle pulses
    always @(posedge sys_clk)
    begin
        if (st.pd_msg_rx)
            st.pd_msg_rx <= 1'b0;
        if (st.request_accepted)
            st.request_accepted <= 1'b0;
    end
    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report
    task automatic chk(input string nm, input int lo, input int hi, input int got);
        tests_run++;
        if (got < lo || got > hi)
        begin
            $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, got);
            n_errors++;
        end
    endtask : chk
    task automatic chkb(input string nm, input logic e, input logic g);
        tests_run++;
        if (g !== e)
        begin
            $display("MISMATCH %s expected %b seen %b", nm, e, g);
            n_errors++;
        end
    endtask : chkb
    // Counts edges until the masked outputs match, first edge is 1
    task automatic wt(input logic [10:0] m, input logic [10:0] v, input int lim, output int k);
        k = -1;
        for (int i = 1; i <= lim && k < 0; i++)
        begin
            @(posedge sys_clk);
            #1;
            if ((drive & m) === v)
                k = i;
        end
        if (k < 0)
        begin
            $display("MISMATCH wait on %h expected %h seen timeout", m, v);
            n_errors++;
            final_report();
        end
    endtask : wt
    task automatic attach(input logic good, output int e);
        int a;
        int b;
        e = 0;
        @(posedge sys_clk);
        st.sink_present <= 1'b1;
        hr_delay <= 8'($urandom_range(4, 1));
        wt(M_AUX, M_AUX, 4, a);
        chk("aux rail", 1, 2, a);
        wt(M_ATT, 11'h000, DEB + 8, b);
        chk("attach debounce", DEB + 1, DEB + 2, a + b);
        if (good)
        begin
            chkb("gate on", 1'b1, drive.nfet_gate_drive);
            chkb("advert with gate", 1'b1, drive.rp_3a_advertise);
            wt(M_RP, M_RP, 3, a);
            wt(M_PROT, M_PROT, PROT + 8, b);
            chk("protection arm", PROT, PROT + 2, a + b);
            e = a + b;
        end
    endtask : attach
    task automatic detach;
        @(posedge sys_clk);
        st.sink_present <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        chkb("detach gate", 1'b0, drive.nfet_gate_drive);
        chkb("detach select", 1'b0, drive.supply_select_0 | drive.supply_select_1);
        chkb("detach indicator", 1'b1, drive.attach_indicator_n);
        repeat (2) @(posedge sys_clk);
    endtask : detach
    initial
    begin
        rst_n = 1'b0;
        st = '0;
        st.gate_disable_input_n = 1'b1;
        st.main_supply_input = 1'b1;
        hr_delay = 8'h01;
        n_errors = 0;
        tests_run = 0;
        n = $urandom(80);
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        attach(1'b1, el);
        wt(M_HR, M_HR, SIL + 10, n);
        chk("silence retry", SIL - 1, SIL + 3, el + n);
        chkb("gate held", 1'b1, drive.nfet_gate_drive);
        wt(M_GATE, 11'h000, HRG + 20, n);
        chk("hard reset hold", hr_delay + HRG, hr_delay + HRG + 4, n);
        wt(M_GATE, M_GATE, 20, n);
        $display("test silence done");
        sel = 2'($urandom_range(3, 1));
        @(posedge sys_clk);
        st.pd_msg_rx <= 1'b1;
        @(posedge sys_clk);
        st.request_accepted <= 1'b1;
        st.request_sel <= sel;
        wt(M_SEL, {4'h0, sel[0], sel[1], 5'h00}, SNK + 8, n);
        chk("select delay", SNK + 1, SNK + 2, n);
        chkb("advert after message", 1'b0, drive.rp_3a_advertise);
        wt(M_RDY, M_RDY, SET + 8, n);
        chk("settle delay", SET, SET + 1, n);
        @(posedge sys_clk);
        st.request_accepted <= 1'b1;
        st.request_sel <= 2'($urandom_range(3, 1));
        repeat (SNK + 5) @(posedge sys_clk);
        detach();
        $display("test transition done");
        st.main_supply_input <= 1'b0;
        attach(1'b0, el);
        wt(M_HR, M_HR, TON + 10, n);
        chk("turn-on retry", TON - 1, TON + 3, n);
        wt(M_HR, M_HR, FLT + HRG + 20, n);
        chk("fault retry", FLT, FLT + HRG + 8, n);
        detach();
        st.main_supply_input <= 1'b1;
        st.vbus_short <= 1'b1;
        attach(1'b0, el);
        wt(M_HR, M_HR, SHT + 10, n);
        wt(M_HR, M_HR, SHT + HRG + 20, n);
        chk("short retry", SHT, SHT + HRG + 8, n);
        detach();
        st.vbus_short <= 1'b0;
        $display("test faults done");
        attach(1'b1, el);
        @(posedge sys_clk);
        st.first_thermal_trip <= 1'b1;
        wt(M_HR, M_HR, 5, n);
        chk("thermal reset", 1, 3, n);
        chkb("bleed kept", 1'b1, drive.bleed_discharge_en);
        chkb("active stopped", 1'b0, drive.active_discharge_en);
        wt(M_GATE, 11'h000, HRG + 20, n);
        @(posedge sys_clk);
        st.first_thermal_trip <= 1'b0;
        // Discharge runs while held off, so a second trip must visibly stop it
        wt(M_DSCG, M_DSCG, 4, n);
        @(posedge sys_clk);
        st.first_thermal_trip <= 1'b1;
        wt(M_DSCG, 11'h000, 4, n);
        chk("discharge stop", 1, 2, n);
        @(posedge sys_clk);
        st.first_thermal_trip <= 1'b0;
        wt(M_GATE, M_GATE, REC + 10, n);
        chk("thermal recovery", REC, REC + 4, n);
        $display("test thermal done");
        for (int k = 0; k < 2; k++)
        begin
            @(posedge sys_clk);
            st.high_current_mode <= 1'b1;
            st.fast_ovp <= (k == 0);
            st.ocp_large <= (k == 1);
            wt(M_GATE, 11'h000, 4, n);
            chk("fast gate off", 1, 2, n);
            @(posedge sys_clk);
            st.fast_ovp <= 1'b0;
            st.ocp_large <= 1'b0;
            wt(M_GATE, M_GATE, HRG + 30, n);
            // Let the hard reset hold end before the next trip
            wt(M_GATE, 11'h000, HRG + 30, n);
            wt(M_GATE, M_GATE, 4, n);
        end
        detach();
        $display("test fast trips done");
        final_report();
    end
endmodule : pdspt_policy_timers_tb
